// *** logic/sipo_params.svh ***
// constants of the serial-in latch driver
// assumes inclusion by the package and the design modules only
`ifndef SIPO_PARAMS_SVH
`define SIPO_PARAMS_SVH

`define SIPO_WIDTH       8
`define SIPO_LAST_STAGE  7
`define SIPO_CHAIN_RST   8'h00
`define SIPO_HOLD_RST    8'h00
`define SIPO_SINK_RST    8'h00
`define SIPO_SYNC_RST    1'h0

`endif

// *** logic/sipo_pkg.sv ***
// types shared by the serial-in latch driver
// assumes sipo_params.svh is on the include path
`include "sipo_params.svh"

package sipo_pkg;
    typedef logic [`SIPO_WIDTH-1:0] stage_word_t;
endpackage

// *** logic/sync_two_flop.sv ***
// two-flop synchroniser for levels or quasi-static words
// assumes the source holds still for several destination clocks
`include "sipo_params.svh"

module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output      logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] dout_d;

    always_comb begin
        meta_d = din;
        dout_d = meta_q;
        if (rst) begin
            meta_d = {WIDTH{`SIPO_SYNC_RST}};
            dout_d = {WIDTH{`SIPO_SYNC_RST}};
        end
    end

    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        dout   <= dout_d;
    end
endmodule

// *** logic/sipo_latch_driver.sv ***
// eight-stage serial shift chain, holding register and gated sink outputs
// assumes shift clock and storage clock come from an outside controller;
// shift chain lives on SHIFT_CLOCK, holding and outputs on CLOCK
`include "sipo_params.svh"

module sipo_latch_driver
    import sipo_pkg::*;
(
    input  wire logic              CLOCK,
    input  wire logic              RST,
    input  wire logic              SHIFT_CLOCK,
    input  wire logic              SHIFT_CHAIN_CLEAR_N,
    input  wire logic              SERIAL_IN,
    input  wire logic              STORAGE_CLOCK,
    input  wire logic              OUTPUT_GATE_N,
    output      logic              SERIAL_CASCADE_OUT,
    output      stage_word_t       SINK_OUT
);
    // shift-clock domain
    stage_word_t chain_q;
    stage_word_t chain_d;

    always_comb begin
        chain_d = {chain_q[`SIPO_LAST_STAGE-1:0], SERIAL_IN};
    end

    // clear acts even while the shift clock is stopped
    always_ff @(posedge SHIFT_CLOCK or negedge SHIFT_CHAIN_CLEAR_N) begin
        if (!SHIFT_CHAIN_CLEAR_N) begin
            chain_q <= `SIPO_CHAIN_RST;
        end else begin
            chain_q <= chain_d;
        end
    end

    assign SERIAL_CASCADE_OUT = chain_q[`SIPO_LAST_STAGE];

    // crossings into the system clock
    stage_word_t chain_sync;
    logic        storage_sync;
    logic        gate_on_sync;
    logic        gate_n_sync;

    sync_two_flop #(.WIDTH(`SIPO_WIDTH)) u_chain_sync (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (chain_q),
        .dout (chain_sync)
    );

    sync_two_flop #(.WIDTH(1)) u_storage_sync (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (STORAGE_CLOCK),
        .dout (storage_sync)
    );

    sync_two_flop #(.WIDTH(1)) u_gate_sync (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (~OUTPUT_GATE_N),
        .dout (gate_on_sync)
    );

    // synced as an enable so reset leaves the sinks gated off
    assign gate_n_sync = ~gate_on_sync;

    // holding register and output buffer
    logic        storage_prev_q;
    logic        storage_prev_d;
    logic        storage_rise;
    stage_word_t hold_q;
    stage_word_t hold_d;
    stage_word_t sink_d;
    stage_word_t sink_q;
    stage_word_t gated_word;

    assign storage_rise = storage_sync & ~storage_prev_q;

    always_comb begin
        storage_prev_d = storage_sync;
        hold_d         = hold_q;
        if (storage_rise) begin
            hold_d = chain_sync;
        end
        if (RST) begin
            storage_prev_d = `SIPO_SYNC_RST;
            hold_d         = `SIPO_HOLD_RST;
        end
    end

    // one turns the sink on, zero turns it off; gate high forces all off
    genvar bit_i;
    generate
        for (bit_i = 0; bit_i < `SIPO_WIDTH; bit_i++) begin : g_gate
            assign gated_word[bit_i] = hold_q[bit_i] & ~gate_n_sync;
        end
    endgenerate

    // single driver for the output flop input
    always_comb begin
        sink_d = gated_word;
        if (RST) begin
            sink_d = `SIPO_SINK_RST;
        end
    end

    always_ff @(posedge CLOCK) begin
        storage_prev_q <= storage_prev_d;
        hold_q         <= hold_d;
        sink_q         <= sink_d;
    end

    assign SINK_OUT = sink_q;

    // checks on the system clock
    property p_hold_capture;
        @(posedge CLOCK) disable iff (RST)
        storage_rise |=> (hold_q == $past(chain_sync));
    endproperty
    a_hold_capture: assert property (p_hold_capture)
        else $error("holding register missed the chain word");

    property p_hold_still;
        @(posedge CLOCK) disable iff (RST)
        !storage_rise |=> $stable(hold_q);
    endproperty
    a_hold_still: assert property (p_hold_still)
        else $error("holding register changed without storage edge");

    property p_clear_zero;
        @(posedge CLOCK) disable iff (RST)
        !SHIFT_CHAIN_CLEAR_N |-> (chain_q == `SIPO_CHAIN_RST) && ($stable(hold_q) || $past(storage_rise));
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("clear did not zero the chain or disturbed holding");

    property p_gate_off;
        @(posedge CLOCK) disable iff (RST)
        gate_n_sync ##1 gate_n_sync |-> (SINK_OUT == `SIPO_SINK_RST);
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("outputs not off while gate high");

    property p_gate_pass;
        @(posedge CLOCK) disable iff (RST)
        !gate_n_sync |=> (SINK_OUT == $past(hold_q));
    endproperty
    a_gate_pass: assert property (p_gate_pass)
        else $error("outputs do not follow holding register");

    property p_sink_map;
        @(posedge CLOCK) disable iff (RST)
        1'b1 |=> (SINK_OUT == ($past(hold_q) & {`SIPO_WIDTH{~$past(gate_n_sync)}}));
    endproperty
    a_sink_map: assert property (p_sink_map)
        else $error("sink bit does not match gated holding bit");

    // reset leaves holding clear and every sink off
    property p_reset_off;
        @(posedge CLOCK)
        RST |=> (SINK_OUT == `SIPO_SINK_RST) && (hold_q == `SIPO_HOLD_RST);
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("sinks or holding not cleared by reset");

    property p_gate_close;
        @(posedge CLOCK) disable iff (RST)
        $rose(gate_n_sync) |=> (SINK_OUT == `SIPO_SINK_RST);
    endproperty
    a_gate_close: assert property (p_gate_close)
        else $error("outputs stayed on after gate went high");

    // host must keep the chain still around a storage edge
    property p_chain_quiet;
        @(posedge CLOCK) disable iff (RST)
        storage_rise |-> $stable(chain_sync);
    endproperty
    a_chain_quiet: assert property (p_chain_quiet)
        else $error("chain word moved while being stored");

    property p_clear_cascade;
        @(posedge CLOCK) disable iff (RST)
        !SHIFT_CHAIN_CLEAR_N |-> !SERIAL_CASCADE_OUT;
    endproperty
    a_clear_cascade: assert property (p_clear_cascade)
        else $error("serial output not low during clear");

    // checks on the shift clock
    property p_cascade;
        @(posedge SHIFT_CLOCK) disable iff (!SHIFT_CHAIN_CLEAR_N)
        1'b1 |=> (SERIAL_CASCADE_OUT == $past(chain_q[`SIPO_LAST_STAGE-1]));
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("serial output is not last stage");

    property p_shift;
        @(posedge SHIFT_CLOCK) disable iff (!SHIFT_CHAIN_CLEAR_N)
        1'b1 |=> (chain_q == {$past(chain_q[`SIPO_LAST_STAGE-1:0]), $past(SERIAL_IN)});
    endproperty
    a_shift: assert property (p_shift)
        else $error("chain did not shift serial input into stage zero");

    c_capture: cover property (@(posedge CLOCK) disable iff (RST) storage_rise ##1 hold_q != `SIPO_HOLD_RST);
    c_gate_on: cover property (@(posedge CLOCK) disable iff (RST) !gate_n_sync ##1 SINK_OUT != `SIPO_SINK_RST);
    c_clear: cover property (@(posedge CLOCK) disable iff (RST) !SHIFT_CHAIN_CLEAR_N ##1 SHIFT_CHAIN_CLEAR_N);
    c_cascade: cover property (@(posedge SHIFT_CLOCK) disable iff (!SHIFT_CHAIN_CLEAR_N) SERIAL_CASCADE_OUT);
    c_gate_off: cover property (@(posedge CLOCK) disable iff (RST) $rose(gate_n_sync) ##1 SINK_OUT == `SIPO_SINK_RST);
endmodule

// *** tb/host_model.sv ***
// host that clocks bytes into the latch driver over the shift link
// assumes the bench calls send_byte; link clock stands still between frames
module host_model (
    output logic shift_clock,
    output logic serial_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        shift_clock = 1'b0;
        serial_in   = 1'b0;
    end

    // msb first, 48 ns link period
    task automatic send_byte(input logic [7:0] word);
        for (int i = 7; i >= 0; i--) begin
            serial_in = word[i];
            #24 shift_clock = 1'b1;
            #24 shift_clock = 1'b0;
        end
        // line no longer meaningful after the frame
        serial_in = ~word[0];
    endtask
endmodule

// *** tb/tb_serial_in_parallel_out_latch_driver.sv ***
// bench for the latch driver: shift, store, gate and clear scenarios
// assumes host_model drives the shift link, bench drives the rest
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); end end

module tb_serial_in_parallel_out_latch_driver
    import sipo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock = 1'b0, rst = 1'b1, clear_n = 1'b0, storage = 1'b0, gate_n = 1'b1;
    logic        shift_clock, serial_in, cascade;
    stage_word_t sink;
    int          num_errors = 0, compares = 0, cycles = 0;

    always #12.5 clock = ~clock;

    host_model host_u (.shift_clock(shift_clock), .serial_in(serial_in));

    sipo_latch_driver dut_u (.CLOCK(clock), .RST(rst), .SHIFT_CLOCK(shift_clock),
        .SHIFT_CHAIN_CLEAR_N(clear_n), .SERIAL_IN(serial_in), .STORAGE_CLOCK(storage),
        .OUTPUT_GATE_N(gate_n), .SERIAL_CASCADE_OUT(cascade), .SINK_OUT(sink));

    task automatic wait_fall(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic pulse_storage();
        wait_fall(4);
        storage = 1'b1;
        wait_fall(3);
        storage = 1'b0;
        wait_fall(6);
    endtask

    // shift a word, check nothing moves before the storage edge
    task automatic load_word(input stage_word_t word, input stage_word_t prev);
        host_u.send_byte(word);
        `CHK(cascade, word[7])
        wait_fall(5);
        `CHK(sink, prev)
        pulse_storage();
        `CHK(sink, gate_n ? 8'h00 : word)
    endtask

    task automatic t_shift_load();
        gate_n = 1'b0;
        wait_fall(5);
        load_word(8'h80, 8'h00);
        load_word(8'h01, 8'h80);
        load_word(8'hA5, 8'h01);
    endtask

    task automatic t_gate();
        gate_n = 1'b1;
        wait_fall(5);
        `CHK(sink, 8'h00)
        load_word(8'h5A, 8'h00);
        gate_n = 1'b0;
        wait_fall(5);
        `CHK(sink, 8'h5A)
    endtask

    task automatic t_clear();
        host_u.send_byte(8'hFF);
        `CHK(cascade, 1'b1)
        wait_fall(1);
        clear_n = 1'b0;
        wait_fall(2);
        `CHK(cascade, 1'b0)
        host_u.send_byte(8'hFF);
        `CHK(cascade, 1'b0)
        `CHK(sink, 8'h5A)
        clear_n = 1'b1;
        pulse_storage();
        `CHK(sink, 8'h00)
    endtask

    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        wait_fall(20);
        rst = 1'b0;
        clear_n = 1'b1;
        wait_fall(2);
        t_shift_load();
        t_gate();
        t_clear();
        end_of_test();
    end
endmodule
